// File: logic/freq_counter_pkg.sv
package freq_counter_pkg;

    // Core clock and the time steps that the counters are built from.
    localparam int unsigned CLK_HZ            = 10_000_000;
    localparam int unsigned GATE_STEP_MS      = 100;
    localparam int unsigned GATE_STEP_CYC     = GATE_STEP_MS * (CLK_HZ / 1000);
    localparam int unsigned DEBOUNCE_STEP_MS  = 5;
    localparam int unsigned DEBOUNCE_STEP_CYC = DEBOUNCE_STEP_MS * (CLK_HZ / 1000);

    // Register indices of the read port.
    localparam logic [15:0] REG_GATE_TIME     = 16'h0004;
    localparam logic [15:0] REG_PERIOD_CYCLES = 16'h0005;
    localparam logic [15:0] REG_DEBOUNCE      = 16'h0006;
    localparam logic [15:0] REG_TRIGGER_EDGE  = 16'h0007;
    localparam logic [15:0] REG_COUNT_CTRL    = 16'h0008;
    localparam logic [15:0] REG_LOW_CUTOFF    = 16'h0009;
    localparam logic [15:0] REG_CH0_RESULT    = 16'h000A;

    // Field layout.
    localparam int unsigned GATE_W      = 4;
    localparam int unsigned PERIOD_W    = 8;
    localparam int unsigned DEBOUNCE_W  = 8;
    localparam int unsigned EDGE_BIT    = 0;
    localparam int unsigned ACQUIRE_BIT = 15;
    localparam int unsigned TERM_BIT    = 0;

    // Values and limits.
    localparam logic [3:0]  GATE_MIN      = 4'h1;
    localparam logic [3:0]  GATE_MAX      = 4'hA;
    localparam logic [15:0] CUTOFF_RESET  = 16'h0005;
    localparam logic [15:0] CUTOFF_MAX    = 16'h2710;
    localparam logic [15:0] COUNT_MAX     = 16'hFFFF;
    localparam logic [1:0]  RANGE_50K     = 2'h0;
    localparam logic [1:0]  RANGE_1K      = 2'h1;
    localparam logic [1:0]  RANGE_100     = 2'h2;
    localparam logic [1:0]  RANGE_EVENT   = 2'h3;

endpackage : freq_counter_pkg

// File: logic/event_if.sv
interface event_if;
    logic       edge_falling;
    logic [7:0] debounce;
    logic       acquire;
    logic       latch;
    logic       clear;
    logic [15:0] count;

    modport ctrl (output edge_falling, output debounce, output acquire, output latch, output clear, input count);
    modport cnt  (input edge_falling, input debounce, input acquire, input latch, input clear, output count);
endinterface : event_if

// File: logic/event_debounce_counter.sv
module event_debounce_counter #(
    parameter int unsigned STEP_CYC = freq_counter_pkg::DEBOUNCE_STEP_CYC
) (
    input  wire logic i_clk,
    input  wire logic i_rst,
    input  wire logic i_sig,
    event_if.cnt      ev
);

    generate
        if (STEP_CYC < 1 || STEP_CYC > 65_000) begin : g_chk
            $error("STEP_CYC out of range");
        end
    endgenerate

    logic        sig_q;
    logic [23:0] holdoff_q;
    logic [15:0] count_q;
    logic        hit;

    // The selected edge is only taken once the previous event's holdoff has run out.
    assign hit      = (ev.edge_falling ? (sig_q & ~i_sig) : (~sig_q & i_sig)) && holdoff_q == 24'h000000;
    assign ev.count = count_q;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            sig_q <= 1'b0;
        end else begin
            sig_q <= i_sig;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst || ev.clear) begin
            holdoff_q <= 24'h000000;
        end else if (hit && ev.acquire) begin
            holdoff_q <= 24'(ev.debounce * STEP_CYC);
        end else if (holdoff_q != 24'h000000) begin
            holdoff_q <= holdoff_q - 24'h000001;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst || ev.clear) begin
            count_q <= 16'h0000;
        end else if (hit && ev.acquire) begin
            if (count_q != freq_counter_pkg::COUNT_MAX) begin
                count_q <= count_q + 16'h0001;
            end else if (!ev.latch) begin
                count_q <= 16'h0000;
            end
        end
    end

    property p_inc;
        @(posedge i_clk) disable iff (i_rst)
        (hit && ev.acquire && !ev.clear && count_q != 16'hFFFF) |=> count_q == $past(count_q) + 16'h0001;
    endproperty
    a_inc: assert property (p_inc) else $error("qualified edge did not count");

    property p_hold;
        @(posedge i_clk) disable iff (i_rst)
        (holdoff_q != 24'h000000 && !ev.clear) |=> count_q == $past(count_q);
    endproperty
    a_hold: assert property (p_hold) else $error("count moved during debounce");

    property p_deb_load;
        @(posedge i_clk) disable iff (i_rst)
        (hit && ev.acquire && !ev.clear) |=> holdoff_q == 24'($past(ev.debounce) * STEP_CYC);
    endproperty
    a_deb_load: assert property (p_deb_load) else $error("debounce delay wrong");

    property p_term;
        @(posedge i_clk) disable iff (i_rst)
        (hit && ev.acquire && !ev.clear && count_q == 16'hFFFF) |=> count_q == (ev.latch ? 16'hFFFF : 16'h0000);
    endproperty
    a_term: assert property (p_term) else $error("terminal count behaviour wrong");

endmodule : event_debounce_counter

// File: logic/dual_frequency_event_counter.sv
// Function
// - Gate time code 1..10 gives code times 0.1 s; code 0 unused.
// - Top range counts input cycles over the gate and derives frequency.
// - Period cycle count is 8 bits, 1..255; upper bits read zero.
// - Lower ranges time N input cycles, average the period, then update.
// - Debounce is 0..255 steps of 5 ms, event inputs only.
// - After an event, further edges are ignored until debounce elapses.
// - Trigger edge bit 0: 0 rising, 1 falling; other bits zero.
// - Count control bit 15 enables acquisition; default disabled.
// - Count control bit 0: 0 auto-reset, 1 latching; bits 14..1 zero.
// - Cutoff is 0..10000 in 0.1 Hz units, default 5.
// - Lower ranges report 0 Hz below the cutoff frequency.
// - Result is a 16-bit unsigned frequency or count.
// - In event mode the result is meaningful only with acquisition enabled.
// - Range code 0 is 50 kHz, 1 is 1 kHz, 2 is 100 Hz, 3 events.
module dual_frequency_event_counter #(
    parameter int unsigned GATE_STEP_CYC     = freq_counter_pkg::GATE_STEP_CYC,
    parameter int unsigned DEBOUNCE_STEP_CYC = freq_counter_pkg::DEBOUNCE_STEP_CYC,
    parameter int unsigned CLK_HZ            = freq_counter_pkg::CLK_HZ
) (
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    input  wire logic        i_sig,
    input  wire logic [1:0]  i_range,
    input  wire logic [3:0]  i_gate_time,
    input  wire logic [7:0]  i_period_cycles,
    input  wire logic [7:0]  i_debounce,
    input  wire logic        i_edge_falling,
    input  wire logic        i_acquire_en,
    input  wire logic        i_latch_mode,
    input  wire logic [15:0] i_cutoff,
    input  wire logic        i_count_clear,
    input  wire logic        i_rd_en,
    input  wire logic [15:0] i_rd_addr,
    output logic      [15:0] o_rd_data,
    output logic             o_rd_valid,
    output logic      [15:0] o_result
);

    generate
        if (GATE_STEP_CYC < 1 || GATE_STEP_CYC > 100_000_000 || CLK_HZ < 1 || CLK_HZ > 100_000_000) begin : g_chk
            $error("gate step or clock rate out of range");
        end
    endgenerate

    typedef enum logic [1:0] {ST_IDLE, ST_GATE, ST_ARM, ST_PERIOD} meas_state_t;

    // Saturate a wide rate to the 16-bit result field.
    function automatic logic [15:0] sat16(input logic [63:0] v);
        sat16 = (v > 64'h000000000000FFFF) ? 16'hFFFF : v[15:0];
    endfunction : sat16

    logic [1:0]  range_q;
    logic [3:0]  gate_q;
    logic [7:0]  period_q;
    logic [7:0]  debounce_q;
    logic        edge_q;
    logic        acq_q;
    logic        latch_q;
    logic [15:0] cutoff_q;
    logic [15:0] result_q;
    logic        sig_q;
    meas_state_t st_q;
    logic [31:0] timer_q;
    logic [23:0] edges_q;
    logic        restart;
    logic        rise;
    logic        gate_ok;
    logic [3:0]  gate_div;
    logic [31:0] gate_len;
    logic        gate_done;
    logic [31:0] gate_total;
    logic [63:0] gate_hz;
    logic [7:0]  per_n;
    logic        per_done;
    logic [63:0] per_elapsed;
    logic [63:0] per_num;
    logic [63:0] per_hz;
    logic        per_below;
    logic        per_timeout;

    event_if ev ();

    event_debounce_counter #(
        .STEP_CYC (DEBOUNCE_STEP_CYC)
    ) u_events (
        .i_clk (i_clk),
        .i_rst (i_rst),
        .i_sig (i_sig),
        .ev    (ev)
    );

    assign ev.edge_falling = edge_q;
    assign ev.debounce     = debounce_q;
    assign ev.acquire      = acq_q && range_q == freq_counter_pkg::RANGE_EVENT;
    assign ev.latch        = latch_q;
    assign ev.clear        = i_count_clear || restart;

    // Any change of range, gate time or period cycle count throws away the measurement in flight,
    // so that a result never mixes two settings of these three.
    assign restart = i_range != range_q || i_gate_time != gate_q || i_period_cycles != period_q;
    assign rise    = i_sig & ~sig_q;

    // Configuration mirror; these copies are what the read port reports.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            range_q    <= freq_counter_pkg::RANGE_50K;
            gate_q     <= 4'h0;
            period_q   <= 8'h00;
            debounce_q <= 8'h00;
            edge_q     <= 1'b0;
            acq_q      <= 1'b0;
            latch_q    <= 1'b0;
            cutoff_q   <= freq_counter_pkg::CUTOFF_RESET;
        end else begin
            range_q    <= i_range;
            gate_q     <= i_gate_time;
            period_q   <= i_period_cycles;
            debounce_q <= i_debounce;
            edge_q     <= i_edge_falling;
            acq_q      <= i_acquire_en;
            latch_q    <= i_latch_mode;
            cutoff_q   <= (i_cutoff > freq_counter_pkg::CUTOFF_MAX) ? freq_counter_pkg::CUTOFF_MAX : i_cutoff;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            sig_q <= 1'b0;
        end else begin
            sig_q <= i_sig;
        end
    end

    // Gated counting for the top range.
    assign gate_ok    = gate_q >= freq_counter_pkg::GATE_MIN && gate_q <= freq_counter_pkg::GATE_MAX;
    assign gate_div   = gate_ok ? gate_q : freq_counter_pkg::GATE_MIN;
    assign gate_len   = 32'(gate_div * GATE_STEP_CYC);
    assign gate_done  = st_q == ST_GATE && timer_q == gate_len - 32'h00000001;
    assign gate_total = 32'(edges_q) + 32'(rise);
    assign gate_hz    = (64'(gate_total) * 64'h000000000000000A) / 64'(gate_div);

    // Averaged period for the two lower ranges; a zero cycle count acts as one.
    assign per_n       = (period_q == 8'h00) ? 8'h01 : period_q;
    assign per_done    = st_q == ST_PERIOD && rise && edges_q + 24'h000001 == 24'(per_n);
    assign per_elapsed = 64'(timer_q) + 64'h0000000000000001;
    assign per_num     = 64'(per_n) * 64'(CLK_HZ);
    assign per_hz      = per_num / per_elapsed;
    assign per_below   = per_num * 64'h000000000000000A < 64'(cutoff_q) * per_elapsed;
    // Once the wait already exceeds per_n periods at the cutoff frequency, the answer is known to be zero.
    assign per_timeout = (st_q == ST_ARM || st_q == ST_PERIOD) && !per_done
                         && 64'(timer_q) * 64'(cutoff_q) > per_num * 64'h000000000000000A;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            st_q    <= ST_IDLE;
            timer_q <= 32'h00000000;
            edges_q <= 24'h000000;
        end else if (restart) begin
            st_q    <= ST_IDLE;
            timer_q <= 32'h00000000;
            edges_q <= 24'h000000;
        end else begin
            case (st_q)
                ST_IDLE: begin
                    timer_q <= 32'h00000000;
                    edges_q <= 24'h000000;
                    if (range_q == freq_counter_pkg::RANGE_50K && gate_ok) begin
                        st_q <= ST_GATE;
                    end else if (range_q == freq_counter_pkg::RANGE_1K || range_q == freq_counter_pkg::RANGE_100) begin
                        st_q <= ST_ARM;
                    end
                end
                ST_GATE: begin
                    if (gate_done) begin
                        timer_q <= 32'h00000000;
                        edges_q <= 24'h000000;
                    end else begin
                        timer_q <= timer_q + 32'h00000001;
                        edges_q <= (edges_q == 24'hFFFFFF) ? edges_q : edges_q + 24'(rise);
                    end
                end
                ST_ARM: begin
                    // Timing starts on an input edge so the window spans whole cycles.
                    edges_q <= 24'h000000;
                    if (rise) begin
                        st_q    <= ST_PERIOD;
                        timer_q <= 32'h00000000;
                    end else if (per_timeout) begin
                        timer_q <= 32'h00000000;
                    end else if (timer_q != 32'hFFFFFFFF) begin
                        timer_q <= timer_q + 32'h00000001;
                    end
                end
                ST_PERIOD: begin
                    if (per_done) begin
                        timer_q <= 32'h00000000;
                        edges_q <= 24'h000000;
                    end else if (per_timeout) begin
                        st_q    <= ST_ARM;
                        timer_q <= 32'h00000000;
                        edges_q <= 24'h000000;
                    end else begin
                        if (timer_q != 32'hFFFFFFFF) begin
                            timer_q <= timer_q + 32'h00000001;
                        end
                        edges_q <= edges_q + 24'(rise);
                    end
                end
                default: begin
                    st_q <= ST_IDLE;
                end
            endcase
        end
    end

    // Result word.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            result_q <= 16'h0000;
        end else if (range_q == freq_counter_pkg::RANGE_EVENT && !restart) begin
            result_q <= acq_q ? ev.count : 16'h0000;
        end else if (restart) begin
            result_q <= 16'h0000;
        end else if (gate_done) begin
            result_q <= sat16(gate_hz);
        end else if (per_done) begin
            result_q <= per_below ? 16'h0000 : sat16(per_hz);
        end else if (per_timeout) begin
            result_q <= 16'h0000;
        end
    end

    assign o_result = result_q;

    // Read port of the input registers; unknown indices read as zero.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_rd_data  <= 16'h0000;
            o_rd_valid <= 1'b0;
        end else begin
            o_rd_valid <= i_rd_en;
            if (!i_rd_en) begin
                o_rd_data <= 16'h0000;
            end else if (i_rd_addr == freq_counter_pkg::REG_GATE_TIME) begin
                o_rd_data <= {12'h000, gate_q};
            end else if (i_rd_addr == freq_counter_pkg::REG_PERIOD_CYCLES) begin
                o_rd_data <= {8'h00, period_q};
            end else if (i_rd_addr == freq_counter_pkg::REG_DEBOUNCE) begin
                o_rd_data <= {8'h00, debounce_q};
            end else if (i_rd_addr == freq_counter_pkg::REG_TRIGGER_EDGE) begin
                o_rd_data <= {15'h0000, edge_q};
            end else if (i_rd_addr == freq_counter_pkg::REG_COUNT_CTRL) begin
                o_rd_data <= {acq_q, 14'h0000, latch_q};
            end else if (i_rd_addr == freq_counter_pkg::REG_LOW_CUTOFF) begin
                o_rd_data <= cutoff_q;
            end else if (i_rd_addr == freq_counter_pkg::REG_CH0_RESULT) begin
                o_rd_data <= result_q;
            end else begin
                o_rd_data <= 16'h0000;
            end
        end
    end

    property p_rd_gate;
        @(posedge i_clk) disable iff (i_rst)
        (i_rd_en && i_rd_addr == 16'h0004) |=> o_rd_valid && o_rd_data == {12'h000, $past(gate_q)};
    endproperty
    a_rd_gate: assert property (p_rd_gate) else $error("gate time read wrong");

    property p_rd_period;
        @(posedge i_clk) disable iff (i_rst)
        (i_rd_en && i_rd_addr == 16'h0005) |=> o_rd_data[15:8] == 8'h00 && o_rd_data[7:0] == $past(period_q);
    endproperty
    a_rd_period: assert property (p_rd_period) else $error("cycle count read wrong");

    property p_rd_ctrl;
        @(posedge i_clk) disable iff (i_rst)
        (i_rd_en && i_rd_addr == 16'h0008) |=> o_rd_data == {$past(acq_q), 14'h0000, $past(latch_q)};
    endproperty
    a_rd_ctrl: assert property (p_rd_ctrl) else $error("count control read wrong");

    property p_cutoff_rst;
        @(posedge i_clk)
        i_rst |=> cutoff_q == 16'h0005 && !acq_q && !latch_q;
    endproperty
    a_cutoff_rst: assert property (p_cutoff_rst) else $error("reset defaults wrong");

    property p_gate_hold;
        @(posedge i_clk) disable iff (i_rst)
        (st_q == ST_GATE && !gate_done && !restart) |=> result_q == $past(result_q);
    endproperty
    a_gate_hold: assert property (p_gate_hold) else $error("result moved inside gate");

    property p_period_hold;
        @(posedge i_clk) disable iff (i_rst)
        (st_q == ST_PERIOD && !per_done && !per_timeout && !restart) |=> $stable(result_q);
    endproperty
    a_period_hold: assert property (p_period_hold) else $error("result moved before cycles done");

    property p_below_cutoff;
        @(posedge i_clk) disable iff (i_rst)
        (per_done && per_below && !restart) |=> result_q == 16'h0000;
    endproperty
    a_below_cutoff: assert property (p_below_cutoff) else $error("below cutoff not zero");

    property p_event_result;
        @(posedge i_clk) disable iff (i_rst)
        (range_q == 2'h3 && !restart) |=> result_q == ($past(acq_q) ? $past(ev.count) : 16'h0000);
    endproperty
    a_event_result: assert property (p_event_result) else $error("event result wrong");

endmodule : dual_frequency_event_counter

// File: verif/signal_source.sv
// Pulse or frequency source standing in for the field signal on the input pin.
// It either runs a square wave of a given half period or holds a level.
module signal_source (
    input  wire logic i_clk,
    output logic      o_sig
);
    timeunit 1ns;
    timeprecision 1ns;

    int half = 0;
    int cnt  = 0;
    logic lvl = 1'b0;

    // A half period of zero means the wave is stopped and the level is held.
    // Only this process drives the pin, so stopping a wave never races its last toggle.
    always @(posedge i_clk) begin
        if (half == 0) begin
            o_sig <= lvl;
        end else if (cnt >= half - 1) begin
            cnt   <= 0;
            o_sig <= ~o_sig;
        end else begin
            cnt <= cnt + 1;
        end
    end

    task automatic run(input int h);
        @(posedge i_clk);
        cnt  <= 0;
        half <= h;
    endtask : run

    task automatic level(input logic v);
        @(posedge i_clk);
        half <= 0;
        lvl  <= v;
    endtask : level
endmodule : signal_source

// File: verif/dual_frequency_event_counter_tb.sv
module dual_frequency_event_counter_tb;
    timeunit 1ns;
    timeprecision 1ns;

    // Short gate, debounce step and clock rate keep the run brief.
    localparam int unsigned GATE_CYC = 10;
    localparam int unsigned DEB_CYC  = 4;
    localparam int unsigned SIM_HZ   = 1000;

    logic        i_clk           = 1'b0;
    logic        i_rst           = 1'b1;
    logic        i_sig;
    logic [1:0]  i_range         = 2'h0;
    logic [3:0]  i_gate_time     = 4'h1;
    logic [7:0]  i_period_cycles = 8'h01;
    logic [7:0]  i_debounce      = 8'h00;
    logic        i_edge_falling  = 1'b0;
    logic        i_acquire_en    = 1'b0;
    logic        i_latch_mode    = 1'b0;
    logic [15:0] i_cutoff        = 16'h0000;
    logic        i_count_clear   = 1'b0;
    logic        i_rd_en         = 1'b0;
    logic [15:0] i_rd_addr       = 16'h0000;
    logic [15:0] o_rd_data;
    logic        o_rd_valid;
    logic [15:0] o_result;
    int          n_fail          = 0;
    int          comparisons     = 0;

    always #50 i_clk = ~i_clk;

    signal_source src (.i_clk(i_clk), .o_sig(i_sig));

    dual_frequency_event_counter #(
        .GATE_STEP_CYC    (GATE_CYC),
        .DEBOUNCE_STEP_CYC(DEB_CYC),
        .CLK_HZ           (SIM_HZ)
    ) dut (
        .i_clk(i_clk), .i_rst(i_rst), .i_sig(i_sig), .i_range(i_range), .i_gate_time(i_gate_time),
        .i_period_cycles(i_period_cycles), .i_debounce(i_debounce), .i_edge_falling(i_edge_falling),
        .i_acquire_en(i_acquire_en), .i_latch_mode(i_latch_mode), .i_cutoff(i_cutoff),
        .i_count_clear(i_count_clear), .i_rd_en(i_rd_en), .i_rd_addr(i_rd_addr),
        .o_rd_data(o_rd_data), .o_rd_valid(o_rd_valid), .o_result(o_result)
    );

    task automatic summarize();
        $display("counts: %0d comparisons, %0d mismatches", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : summarize

    task automatic chk16(input logic [15:0] got, input logic [15:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk16

    task automatic chk1(input logic got, input logic exp, input string what);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: %s got %b expected %b", $time, what, got, exp);
        end
    endtask : chk1

    task automatic rd(input logic [15:0] a, input logic [15:0] exp);
        @(posedge i_clk);
        i_rd_en   <= 1'b1;
        i_rd_addr <= a;
        @(posedge i_clk);
        i_rd_en <= 1'b0;
        @(negedge i_clk);
        chk1(o_rd_valid, 1'b1, "read valid");
        chk16(o_rd_data, exp, "read data");
    endtask : rd

    // Two settling edges let the design see the change before results are judged.
    task automatic cfg(input logic [1:0] r, input logic [3:0] g, input logic [7:0] p, input logic [15:0] c);
        @(posedge i_clk);
        i_range         <= r;
        i_gate_time     <= g;
        i_period_cycles <= p;
        i_cutoff        <= c;
        repeat (2) @(posedge i_clk);
        @(negedge i_clk);
    endtask : cfg

    task automatic wait_result(input int lim, output int cyc);
        cyc = 0;
        while (o_result === 16'h0000 && cyc < lim) begin
            @(negedge i_clk);
            cyc++;
        end
    endtask : wait_result

    task automatic ev(input logic v);
        src.level(v);
        repeat (4) @(posedge i_clk);
        @(negedge i_clk);
    endtask : ev

    task automatic pulse_clear();
        @(posedge i_clk);
        i_count_clear <= 1'b1;
        @(posedge i_clk);
        i_count_clear <= 1'b0;
    endtask : pulse_clear

    task automatic ev_set(input logic [7:0] d, input logic f, input logic a, input logic l);
        @(posedge i_clk);
        i_debounce     <= d;
        i_edge_falling <= f;
        i_acquire_en   <= a;
        i_latch_mode   <= l;
    endtask : ev_set

    task automatic t_reset();
        @(posedge i_clk);
        @(negedge i_clk);
        chk16(o_result, 16'h0000, "result in reset");
        chk1(o_rd_valid, 1'b0, "valid in reset");
        @(posedge i_clk);
        i_rst     <= 1'b0;
        i_rd_en   <= 1'b1;
        i_rd_addr <= freq_counter_pkg::REG_LOW_CUTOFF;
        @(posedge i_clk);
        i_rd_en <= 1'b0;
        @(negedge i_clk);
        chk16(o_rd_data, freq_counter_pkg::CUTOFF_RESET, "cutoff default");
        $display("test reset done");
    endtask : t_reset

    task automatic t_regs();
        logic [15:0] exp [6];
        exp = '{16'h000A, 16'h00FF, 16'h0080, 16'h0001, 16'h8001, 16'h2710};
        ev_set(8'h80, 1'b1, 1'b1, 1'b1);
        cfg(2'h3, 4'hA, 8'hFF, 16'h2710);
        foreach (exp[k]) rd(16'(k + 4), exp[k]);
        @(posedge i_clk);
        i_rd_en   <= 1'b1;
        i_rd_addr <= 16'h0005;
        @(posedge i_clk);
        i_rd_addr <= 16'h000B;
        @(negedge i_clk);
        chk16(o_rd_data, 16'h00FF, "back to back first");
        @(posedge i_clk);
        i_rd_en <= 1'b0;
        @(negedge i_clk);
        chk1(o_rd_valid, 1'b1, "unmapped valid");
        chk16(o_rd_data, 16'h0000, "unmapped data");
        @(negedge i_clk);
        chk1(o_rd_valid, 1'b0, "valid one cycle");
        $display("test registers done");
    endtask : t_regs

    task automatic t_gate();
        logic [3:0] codes [3];
        int         cyc;
        codes = '{4'h1, 4'h2, 4'hA};
        src.run(1);
        foreach (codes[k]) begin
            cfg(2'h0, codes[k], 8'h01, 16'h0005);
            wait_result(25 * codes[k] + 20, cyc);
            chk16(o_result, 16'h0032, "gated frequency");
        end
        cfg(2'h0, 4'h0, 8'h01, 16'h0005);
        repeat (300) @(negedge i_clk);
        chk16(o_result, 16'h0000, "unused gate code");
        $display("test gate done");
    endtask : t_gate

    task automatic t_period();
        logic [7:0] ns [3];
        int         neff;
        int         cyc;
        ns = '{8'h00, 8'h01, 8'hFF};
        src.run(5);
        for (int r = 1; r <= 2; r++) begin
            foreach (ns[k]) begin
                neff = (ns[k] == 8'h00) ? 1 : int'(ns[k]);
                cfg(2'(r), 4'h1, ns[k], 16'h0005);
                wait_result(10 * neff + 40, cyc);
                chk16(o_result, 16'h0064, "period average");
                chk1(cyc >= 10 * neff - 4, 1'b1, "update after all cycles");
            end
        end
        $display("test period done");
    endtask : t_period

    task automatic t_cutoff();
        int cyc;
        cfg(2'h1, 4'h1, 8'h04, 16'h03E9);
        repeat (150) @(negedge i_clk);
        chk16(o_result, 16'h0000, "below cutoff");
        cfg(2'h2, 4'h1, 8'h04, 16'h03E8);
        wait_result(100, cyc);
        chk16(o_result, 16'h0064, "at cutoff");
        $display("test cutoff done");
    endtask : t_cutoff

    task automatic t_event();
        ev_set(8'h00, 1'b0, 1'b1, 1'b0);
        src.level(1'b0);
        cfg(2'h3, 4'h1, 8'h01, 16'h0005);
        repeat (3) begin
            ev(1'b1);
            ev(1'b0);
        end
        chk16(o_result, 16'h0003, "rising events");
        rd(freq_counter_pkg::REG_CH0_RESULT, 16'h0003);
        rd(freq_counter_pkg::REG_COUNT_CTRL, 16'h8000);
        ev_set(8'h00, 1'b1, 1'b1, 1'b0);
        pulse_clear();
        ev(1'b1);
        chk16(o_result, 16'h0000, "rise ignored in falling mode");
        ev(1'b0);
        chk16(o_result, 16'h0001, "falling event");
        ev_set(8'h00, 1'b1, 1'b0, 1'b0);
        ev(1'b1);
        ev(1'b0);
        chk16(o_result, 16'h0000, "acquire off");
        ev_set(8'h00, 1'b1, 1'b1, 1'b0);
        ev(1'b1);
        chk16(o_result, 16'h0001, "count held while off");
        ev_set(8'h02, 1'b0, 1'b1, 1'b0);
        src.level(1'b0);
        pulse_clear();
        src.level(1'b1);
        src.level(1'b0);
        src.level(1'b1);
        // Long enough that a second, wrongly taken edge would already show in the result.
        repeat (5) @(negedge i_clk);
        chk16(o_result, 16'h0001, "edge inside debounce");
        repeat (20) @(posedge i_clk);
        ev(1'b0);
        ev(1'b1);
        chk16(o_result, 16'h0002, "edge after debounce");
        pulse_clear();
        repeat (2) @(negedge i_clk);
        chk16(o_result, 16'h0000, "count cleared");
        $display("test event done");
    endtask : t_event

    // Worst case is well under ten thousand cycles; the limit leaves ample slack.
    initial begin
        repeat (40000) @(posedge i_clk);
        n_fail++;
        $display("unexpected at %0t: watchdog expired", $time);
        summarize();
    end

    initial begin
        t_reset();
        t_regs();
        t_gate();
        t_period();
        t_cutoff();
        t_event();
        summarize();
    end
endmodule : dual_frequency_event_counter_tb
